// *** psbp_unit_end.sv ***
/*
  program store end: decodes each control code, sources memory, pointer,
  vector and port bytes, accepts bytes from the processor, and owns the
  two parallel port latches.
  assumes the processor end frames each cycle with cycle_start and write_clk.
*/
// Behaviour
// RULE1 - processor supplies control code each cycle
// RULE2 - processor supplies both clocks for timing
// RULE3 - memory codes drive only inside own segment
// RULE4 - memory reads use program or data pointer
// RULE5 - pointer bytes placed on bus on request
// RULE6 - vector bytes only when interrupt source
// RULE7 - code 1b drives own selected port
// RULE8 - processor drives stores, port and registers
// RULE9 - code 1c processor drives byte or address
// RULE10 - flag low while unit data stable
// RULE11 - flag held into next cycle briefly
// RULE12 - data ready before processor setup needs
// RULE13 - add bus byte to 16-bit value
// RULE14 - two ports decoded, upper select fixed
// RULE15 - input reads pins, output loads latch
// RULE16 - each pin latch holds last value
// RULE17 - port transfer spans three cycles, address first
// RULE18 - second cycle routes data latch or pins
// RULE19 - value captured at second cycle end
// RULE20 - third cycle is next instruction fetch
// RULE21 - otherwise bus released and flag high
`timescale 1ns/1ns
module psbp_unit_end (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  psbp_if.unit link,
  input wire logic [5:0] seg_sel_i,
  input wire logic [5:0] port_sel_i,
  input wire logic irq_source_i,
  input wire logic [7:0] port_a_pins_i,
  input wire logic [7:0] port_b_pins_i,
  output logic [7:0] port_a_latch_o,
  output logic [7:0] port_b_latch_o,
  output logic [15:0] program_pointer_o
);
  typedef struct packed {
    logic [15:0] pp;
    logic [15:0] spp;
    logic [15:0] dp;
    logic [7:0] out;
    logic oe;
    logic flag;              // 1 = flag asserted (pin low)
    logic [1:0] rel_cnt;
    logic [7:0] pa;
    logic [7:0] pb;
    logic [7:0] port_addr;
    psbp_pkg::psbp_phase_t ph;
  } psbp_unit_st_t;
  psbp_unit_st_t st, next_st;

  logic [7:0] store_mem [psbp_pkg::STORE_DEPTH];
  logic [15:0] mem_addr;
  logic in_seg;
  logic port_hit;
  logic [7:0] mem_byte;
  logic [15:0] sum;

  // ************************************************************
  // address, segment and port decode
  // ************************************************************
  always_comb begin
    mem_addr = (link.cpu_control_code == psbp_pkg::CC_OPND_DP) ? st.dp : st.pp; // RULE4
    in_seg = (mem_addr[15:10] == seg_sel_i); // RULE3
    port_hit = (st.port_addr[7:2] == port_sel_i) & ~st.port_addr[1]; // RULE14
    mem_byte = store_mem[mem_addr[9:0]];
    // sign-extended byte into the 16-bit adder, single clock RULE13
    sum = st.pp + {{8{link.bus[7]}}, link.bus};
  end

  // ************************************************************
  // code decode and sequencing
  // ************************************************************
  always_comb begin
    next_st = st;
    if (link.cycle_start) begin
      next_st.oe = 1'b0; // RULE21
      case (link.cpu_control_code)
        psbp_pkg::CC_FETCH, psbp_pkg::CC_BOFS, psbp_pkg::CC_OPND_DP,
        psbp_pkg::CC_OPND_PP, psbp_pkg::CC_PP_LOAD_LO, psbp_pkg::CC_DP_LOAD_LO,
        psbp_pkg::CC_DP_LOAD_HI: begin
          next_st.out = mem_byte; // RULE4
          next_st.oe = in_seg; // RULE3
        end
        psbp_pkg::CC_DP_HI: begin next_st.out = st.dp[15:8]; next_st.oe = 1'b1; end // RULE5
        psbp_pkg::CC_DP_LO: begin next_st.out = st.dp[7:0]; next_st.oe = 1'b1; end // RULE5
        psbp_pkg::CC_SPP_HI: begin next_st.out = st.spp[15:8]; next_st.oe = 1'b1; end // RULE5
        psbp_pkg::CC_SPP_LO: begin next_st.out = st.spp[7:0]; next_st.oe = 1'b1; end // RULE5
        psbp_pkg::CC_PP_LO: begin next_st.out = st.pp[7:0]; next_st.oe = 1'b1; end // RULE5
        psbp_pkg::CC_PP_HI: begin next_st.out = st.pp[15:8]; next_st.oe = 1'b1; end // RULE5
        psbp_pkg::CC_VEC_LO: begin
          next_st.out = psbp_pkg::VEC_DEFAULT[7:0];
          next_st.oe = irq_source_i; // RULE6
        end
        psbp_pkg::CC_VEC_HI: begin
          next_st.out = psbp_pkg::VEC_DEFAULT[15:8];
          next_st.oe = irq_source_i; // RULE6
        end
        psbp_pkg::CC_PORT_RD: begin
          // second cycle of an input: pins onto the bus RULE7 RULE15 RULE18
          next_st.out = st.port_addr[0] ? port_b_pins_i : port_a_pins_i;
          next_st.oe = port_hit;
          next_st.ph = psbp_pkg::PSBP_PH_DATA;
        end
        psbp_pkg::CC_PORT_WR: next_st.ph = psbp_pkg::PSBP_PH_DATA; // RULE18
        default: next_st.ph = psbp_pkg::PSBP_PH_IDLE; // RULE20
      endcase
      // flag goes low with the data, both registered at the end of the cycle_start clock RULE10 RULE12
      if (next_st.oe) begin
        next_st.flag = 1'b1;
        next_st.rel_cnt = 2'(psbp_pkg::REL_CYC);
      end else if (st.flag) begin
        // previous cycle drove: hold into this cycle for the release delay RULE11
        next_st.rel_cnt = 2'(psbp_pkg::REL_CYC);
      end
    end else if (st.flag && !st.oe) begin
      if (st.rel_cnt <= 2'h1) begin
        next_st.flag = 1'b0; // RULE11
      end else begin
        next_st.rel_cnt = st.rel_cnt - 2'h1;
      end
    end
    // closing edge of the cycle: pointer updates and captures
    if (link.write_clk) begin
      case (link.cpu_control_code)
        psbp_pkg::CC_FETCH, psbp_pkg::CC_OPND_PP: next_st.pp = st.pp + psbp_pkg::ONE_WORD;
        psbp_pkg::CC_BOFS: next_st.pp = sum; // RULE13
        psbp_pkg::CC_OPND_DP: next_st.dp = st.dp + psbp_pkg::ONE_WORD;
        psbp_pkg::CC_PP_LOAD_LO, psbp_pkg::CC_REG_PP_LO, psbp_pkg::CC_REG_PP_LO2:
          next_st.pp[7:0] = link.bus;
        psbp_pkg::CC_REG_PP_HI: next_st.pp[15:8] = link.bus;
        psbp_pkg::CC_DP_LOAD_LO, psbp_pkg::CC_REG_DP_LO: next_st.dp[7:0] = link.bus;
        psbp_pkg::CC_DP_LOAD_HI, psbp_pkg::CC_REG_DP_HI: next_st.dp[15:8] = link.bus;
        psbp_pkg::CC_REG_SPP_HI: next_st.spp[15:8] = link.bus;
        psbp_pkg::CC_REG_SPP_LO: next_st.spp[7:0] = link.bus;
        psbp_pkg::CC_IDLE: next_st.dp = st.dp + {{8{link.bus[7]}}, link.bus}; // RULE13
        psbp_pkg::CC_PORT_ADDR: next_st.port_addr = link.bus; // RULE17
        psbp_pkg::CC_PORT_WR: begin
          // latch captured at end of second cycle RULE15 RULE16 RULE19
          if (port_hit && !st.port_addr[0]) next_st.pa = link.bus;
          if (port_hit && st.port_addr[0]) next_st.pb = link.bus;
        end
        default: next_st.pp = st.pp;
      endcase
      if (st.ph == psbp_pkg::PSBP_PH_DATA) next_st.ph = psbp_pkg::PSBP_PH_FETCH; // RULE20
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // store contents are loaded by the testbench through hierarchy; no write path
  assign link.unit_bus_out = st.out;
  assign link.unit_bus_oe = st.oe; // RULE21
  assign link.bus_drive_flag_n = ~st.flag; // RULE10
  assign port_a_latch_o = st.pa; // RULE16
  assign port_b_latch_o = st.pb;
  assign program_pointer_o = st.pp;
endmodule // psbp_unit_end

// *** psbp_pkg.sv ***
/*
  shared constants and types for the program store bus port: control codes,
  bus widths, address segment and port select defaults.
  assumes both ends run on one 20 MHz system clock.
*/
package psbp_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int CODE_W = 5;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int SEG_W = 6;
  localparam int SEL_W = 6;
  // ************************************************************
  // control codes
  // ************************************************************
  localparam logic [4:0] CC_FETCH = 5'h00;
  localparam logic [4:0] CC_BOFS = 5'h01;
  localparam logic [4:0] CC_OPND_DP = 5'h02;
  localparam logic [4:0] CC_OPND_PP = 5'h03;
  localparam logic [4:0] CC_IDLE = 5'h04;
  localparam logic [4:0] CC_STORE = 5'h05;
  localparam logic [4:0] CC_DP_HI = 5'h06;
  localparam logic [4:0] CC_SPP_HI = 5'h07;
  localparam logic [4:0] CC_DP_LO = 5'h09;
  localparam logic [4:0] CC_SPP_LO = 5'h0b;
  localparam logic [4:0] CC_PP_LOAD_LO = 5'h0c;
  localparam logic [4:0] CC_DP_LOAD_LO = 5'h0e;
  localparam logic [4:0] CC_VEC_LO = 5'h0f;
  localparam logic [4:0] CC_DP_LOAD_HI = 5'h11;
  localparam logic [4:0] CC_REG_PP_LO = 5'h12;
  localparam logic [4:0] CC_VEC_HI = 5'h13;
  localparam logic [4:0] CC_REG_PP_HI = 5'h14;
  localparam logic [4:0] CC_REG_SPP_HI = 5'h15;
  localparam logic [4:0] CC_REG_DP_HI = 5'h16;
  localparam logic [4:0] CC_REG_PP_LO2 = 5'h17;
  localparam logic [4:0] CC_REG_SPP_LO = 5'h18;
  localparam logic [4:0] CC_REG_DP_LO = 5'h19;
  localparam logic [4:0] CC_PORT_WR = 5'h1a;
  localparam logic [4:0] CC_PORT_RD = 5'h1b;
  localparam logic [4:0] CC_PORT_ADDR = 5'h1c;
  localparam logic [4:0] CC_PP_LO = 5'h1e;
  localparam logic [4:0] CC_PP_HI = 5'h1f;
  // ************************************************************
  // segment and port decode
  // ************************************************************
  localparam logic [5:0] SEG_DEFAULT = 6'h00;   // upper address bits owned by the unit
  localparam logic [5:0] SEL_DEFAULT = 6'h01;   // upper port address bits of the unit
  localparam logic [1:0] PORT_A_LOW = 2'h0;
  localparam logic [1:0] PORT_B_LOW = 2'h1;
  localparam logic [15:0] VEC_DEFAULT = 16'h0080;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] ONE_WORD = 16'h0001;
  localparam int STORE_DEPTH = 1024;
  localparam int STORE_AW = 10;
  // bus_drive_flag release delay into the next cycle
  localparam int REL_DELAY_NS = 50;
  localparam int CLK_NS = 50;
  localparam int REL_CYC = (REL_DELAY_NS + CLK_NS - 1) / CLK_NS;
  // three-cycle port transfer phases
  typedef enum logic [1:0] {PSBP_PH_IDLE, PSBP_PH_DATA, PSBP_PH_FETCH} psbp_phase_t;
endpackage

// *** psbp_if.sv ***
/*
  link between the processor end and the program store end: control code,
  shared 8-bit bus as input, output and enable per party, and the drive flag.
  resolves the bus itself from the two enables, processor first.
*/
`timescale 1ns/1ns
interface psbp_if;
  logic [4:0] cpu_control_code;
  logic cycle_start;           // first clock of each instruction cycle
  logic write_clk;             // high on the clock that ends a cycle
  logic [7:0] cpu_bus_out;
  logic cpu_bus_oe;
  logic [7:0] unit_bus_out;
  logic unit_bus_oe;
  logic bus_drive_flag_n;      // open drain, low while unit data is stable
  logic [7:0] bus;
  // mux of the two drivers, processor first, 8'hff when neither drives; both enabled is a contention fault
  assign bus = cpu_bus_oe ? cpu_bus_out : (unit_bus_oe ? unit_bus_out : 8'hff);
  modport cpu (
    output cpu_control_code, cycle_start, write_clk, cpu_bus_out, cpu_bus_oe,
    input bus, bus_drive_flag_n
  );
  modport unit (
    input cpu_control_code, cycle_start, write_clk, bus,
    output unit_bus_out, unit_bus_oe, bus_drive_flag_n
  );
endinterface

// *** psbp_cpu_end.sv ***
/*
  processor end: issues one control code per instruction cycle and drives the
  shared bus on the codes where the processor is the source.
  assumes one instruction cycle per request of two clocks.
*/
`timescale 1ns/1ns
module psbp_cpu_end (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  psbp_if.cpu link,
  input wire logic req_valid_i,
  input wire logic [4:0] req_code_i,
  input wire logic [7:0] req_data_i,
  input wire logic req_port_short_i,
  output logic req_ready_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_valid_o
);
  typedef struct packed {
    logic busy;
    logic phase;        // 0 first clock, 1 closing clock
    logic [4:0] code;
    logic [7:0] data;
    logic drive;
    logic [7:0] rsp;
    logic rsp_v;
  } psbp_cpu_st_t;
  psbp_cpu_st_t st, next_st;

  // ************************************************************
  // cycle sequencer
  // ************************************************************
  // a request becomes a two-clock instruction cycle; processor drives the
  // bus only on codes where it is the source
  always_comb begin
    next_st = st;
    next_st.rsp_v = 1'b0;
    if (!st.busy) begin
      if (req_valid_i) begin
        next_st.busy = 1'b1;
        next_st.phase = 1'b0;
        next_st.code = req_code_i; // RULE1
        next_st.data = req_data_i;
        case (req_code_i)
          psbp_pkg::CC_STORE, psbp_pkg::CC_PORT_WR, psbp_pkg::CC_REG_PP_LO,
          psbp_pkg::CC_REG_PP_HI, psbp_pkg::CC_REG_SPP_HI, psbp_pkg::CC_REG_DP_HI,
          psbp_pkg::CC_REG_PP_LO2, psbp_pkg::CC_REG_SPP_LO,
          psbp_pkg::CC_REG_DP_LO: next_st.drive = 1'b1; // RULE8
          psbp_pkg::CC_PORT_ADDR: next_st.drive = req_port_short_i; // RULE9 RULE17
          default: next_st.drive = 1'b0;
        endcase
      end
    end else if (!st.phase) begin
      next_st.phase = 1'b1;
    end else begin
      next_st.busy = 1'b0;
      next_st.drive = 1'b0;
      next_st.rsp = link.bus;   // capture at cycle end, the write edge RULE19
      next_st.rsp_v = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.cpu_control_code = st.code;
  assign link.cycle_start = st.busy & ~st.phase; // RULE2
  assign link.write_clk = st.busy & st.phase;
  assign link.cpu_bus_out = st.data;
  // drive only in the closing clock: the unit may still hold the bus from the
  // previous cycle during the first clock, so this avoids a contention clock
  assign link.cpu_bus_oe = st.drive & st.busy & st.phase;
  assign req_ready_o = ~st.busy;
  assign rsp_data_o = st.rsp;
  assign rsp_valid_o = st.rsp_v;
endmodule // psbp_cpu_end

// *** psbp_sva.sv ***
/*
  checker for the link between the two ends of the program store bus port.
  assumes it is instantiated beside the interface, fed its signals by name.
*/
`timescale 1ns/1ns
module psbp_sva (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [4:0] cpu_control_code,
  input wire logic cycle_start,
  input wire logic write_clk,
  input wire logic [7:0] cpu_bus_out,
  input wire logic cpu_bus_oe,
  input wire logic [7:0] unit_bus_out,
  input wire logic unit_bus_oe,
  input wire logic bus_drive_flag_n,
  input wire logic [7:0] bus
);
  // ************************************************************
  // link properties
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // two parties on the bus at once would corrupt both values
  a_no_contention: assert property (!(cpu_bus_oe && unit_bus_oe))
    else $error("both ends drive the bus");
  a_cycle_framing: assert property (cycle_start |=> write_clk)
    else $error("cycle start not followed by write clock");
  a_code_stands: assert property (cycle_start |=> $stable(cpu_control_code))
    else $error("control code changed inside a cycle");
  a_flag_with_drive: assert property (unit_bus_oe |-> !bus_drive_flag_n)
    else $error("unit drives bus with flag high");
  a_pointer_drive: assert property (cycle_start && (cpu_control_code inside
    {5'h06, 5'h07, 5'h09, 5'h0b, 5'h1e, 5'h1f}) |=> unit_bus_oe)
    else $error("pointer byte not driven");
  a_idle_quiet: assert property (cycle_start && cpu_control_code == 5'h04
    |=> !unit_bus_oe)
    else $error("unit drove on an idle code");
  a_cpu_source: assert property (cycle_start && (cpu_control_code inside
    {5'h05, 5'h12, [5'h14:5'h1a]}) |=> cpu_bus_oe)
    else $error("processor did not drive its byte");
  // the flag outlives the drive by one clock into the next cycle
  a_flag_holds: assert property ($fell(unit_bus_oe) |-> !bus_drive_flag_n)
    else $error("flag released with the drive");
  a_flag_release: assert property ((!unit_bus_oe)[*3] |-> bus_drive_flag_n)
    else $error("flag held too long");
  a_data_steady: assert property (unit_bus_oe && $past(unit_bus_oe)
    && !$past(cycle_start) |-> $stable(unit_bus_out))
    else $error("unit data moved while driven");
endmodule // psbp_sva

// *** program_store_bus_port_tb.sv ***
/*
  testbench joining the processor end and the program store end.
  assumes a 20 MHz clock and one request per instruction cycle.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module program_store_bus_port_tb;
  logic clk_sys_i = 0, rst_i = 1, req_valid = 0, irq = 0, drv;
  logic [4:0] req_code = 0;
  logic [7:0] req_data = 0, rsp, pins_a = 0, pins_b = 0, rsp_data, lat_a, lat_b;
  logic [5:0] seg = 0, psel = psbp_pkg::SEL_DEFAULT;
  logic req_ready, rsp_valid;
  logic [15:0] pp;
  int n_fail = 0, n_tests = 0, cyc = 0;
  psbp_if link();
  psbp_cpu_end u_psbp_cpu_end (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
    .req_valid_i(req_valid), .req_code_i(req_code), .req_data_i(req_data),
    .req_port_short_i(1'b1), .req_ready_o(req_ready), .rsp_data_o(rsp_data),
    .rsp_valid_o(rsp_valid));
  psbp_unit_end u_psbp_unit_end (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
    .seg_sel_i(seg), .port_sel_i(psel), .irq_source_i(irq), .port_a_pins_i(pins_a),
    .port_b_pins_i(pins_b), .port_a_latch_o(lat_a), .port_b_latch_o(lat_b),
    .program_pointer_o(pp));
  psbp_sva u_psbp_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cpu_control_code(link.cpu_control_code), .cycle_start(link.cycle_start),
    .write_clk(link.write_clk), .cpu_bus_out(link.cpu_bus_out),
    .cpu_bus_oe(link.cpu_bus_oe), .unit_bus_out(link.unit_bus_out),
    .unit_bus_oe(link.unit_bus_oe), .bus_drive_flag_n(link.bus_drive_flag_n),
    .bus(link.bus));
  // ************************************************************
  // clock and hang guard
  // ************************************************************
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // a whole run needs some 100 clocks, so 3000 only trips on a hang
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  // one instruction cycle: hold the request until taken, then await the answer
  task automatic xfer(input logic [4:0] c, input logic [7:0] d);
    int n;
    n = 0;
    drv = 0;
    @(negedge clk_sys_i);
    req_valid = 1;
    req_code = c;
    req_data = d;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    @(negedge clk_sys_i);
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    // flag judged after the closing edge: a flag held over from the previous
    // cycle is released by then, the flag of this cycle still stands
    drv = (link.bus_drive_flag_n === 1'b0);
    rsp = rsp_data;
    if (n >= 20) n_fail++;
  endtask
  task automatic t_pointer();
    xfer(5'h14, 8'h12);
    xfer(5'h12, 8'h34);
    `CHK("pp", 16'h1234, pp)
    xfer(5'h1f, 8'h00);
    `CHK("pp hi", 8'h12, rsp)
    `CHK("flag", 1'b1, drv)
    xfer(5'h1e, 8'h00);
    `CHK("pp lo", 8'h34, rsp)
    $display("pointer test done");
  endtask
  task automatic t_segment();
    xfer(5'h00, 8'h00);
    `CHK("out of seg", 8'hff, rsp)
    `CHK("no flag", 1'b0, drv)
    seg = 6'h04;
    u_psbp_unit_end.store_mem[10'h234] = 8'h6e;
    xfer(5'h14, 8'h12);
    xfer(5'h12, 8'h34);
    xfer(5'h00, 8'h00);
    `CHK("in seg", 1'b1, drv)
    `CHK("mem byte", 8'h6e, rsp)
    `CHK("pp step", 16'h1235, pp)
    $display("segment test done");
  endtask
  task automatic t_vector();
    xfer(5'h0f, 8'h00);
    `CHK("no vec", 8'hff, rsp)
    irq = 1;
    xfer(5'h0f, 8'h00);
    `CHK("vec lo", psbp_pkg::VEC_DEFAULT[7:0], rsp)
    xfer(5'h13, 8'h00);
    `CHK("vec hi", psbp_pkg::VEC_DEFAULT[15:8], rsp)
    xfer(5'h04, 8'h00);
    `CHK("idle", 8'hff, rsp)
    $display("vector test done");
  endtask
  task automatic t_port();
    xfer(5'h1c, {psel, 2'h0});
    xfer(5'h1a, 8'ha5);
    xfer(5'h00, 8'h00);
    `CHK("latch a", 8'ha5, lat_a)
    xfer(5'h1c, {psel, 2'h1});
    xfer(5'h1a, 8'h3c);
    xfer(5'h00, 8'h00);
    `CHK("latch b", 8'h3c, lat_b)
    `CHK("latch a kept", 8'ha5, lat_a)
    pins_a = 8'h5a;
    pins_b = 8'hc3;
    xfer(5'h1c, {psel, 2'h0});
    xfer(5'h1b, 8'h00);
    `CHK("pins a", 8'h5a, rsp)
    xfer(5'h1c, {psel, 2'h1});
    xfer(5'h1b, 8'h00);
    `CHK("pins b", 8'hc3, rsp)
    xfer(5'h1c, {psel ^ 6'h01, 2'h0});
    xfer(5'h1b, 8'h00);
    `CHK("port miss", 8'hff, rsp)
    `CHK("no miss flag", 1'b0, drv)
    $display("port test done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 0;
    t_pointer();
    t_segment();
    t_vector();
    t_port();
    print_verdict();
  end
endmodule // program_store_bus_port_tb
